// ---- pkg/bus_sensor_defs.vh ----
// Constants for the bus sensor slave logic.
//
// Operation
// - Filtered supply reset; re-initialise before commands.
// - Bus below frame threshold starts a word.
// - Signal falls open bits; count low, high.
// - Longer low means zero, longer high one.
// - Bus back to idle ends the word.
// - Bus low beyond timeout resets the device.
// - Bad check bits or length: ignore word.
// - Everything runs from one 10 MHz clock.
// - LFSR bitstream dithers the oscillator.
// - Sample command alone starts a conversion.
// - Clamp results into 0020 to 03E3.
// - Conversion fault reports code 03F8.
// - Pin one input high forces error code.
// - Each bit start switches response current.
// - Response current off while bus idle.
// - Pass-through switch obeys bus commands.
// - Switch opens on clear, timeout, supply.
// - Only initialise command closes the switch.
// - Logic pins default inputs; set individually.
// - Store 4-bit address at initialisation.
// - Check bits: x^4+1, seed 1010.
// - Long word: data, address, command, check.
// - Reply goes out during next word.
// - Corrupted word drops pending response.
`ifndef BUS_SENSOR_DEFS_VH
`define BUS_SENSOR_DEFS_VH

// Clock rate in MHz and the derived timing counts.
`define CLK_MHZ 10
`define BUS_TIMEOUT_US 2000
`define BUS_TIMEOUT_CYC (`BUS_TIMEOUT_US * `CLK_MHZ)
`define POR_MASK_NS 3500
`define POR_MASK_CYC ((`POR_MASK_NS * `CLK_MHZ + 999) / 1000)

// Word sizes in bits.
`define WORD_LONG_BITS 5'h14
`define WORD_SHORT_BITS 5'h0c

// Check-bit seed.
`define CRC_SEED 4'ha

// Command codes.
`define CMD_INIT 4'h0
`define CMD_SAMPLE_ZERO 4'h1
`define CMD_SAMPLE_ONE 4'h2
`define CMD_PIN_CTRL 4'h3
`define CMD_PIN_READ 4'h4
`define CMD_CLEAR 4'hf

// Address field that an uninitialised device answers to.
`define INIT_ADDR 4'h0

// Data bit of the initialise command that closes the switch.
`define SWITCH_CLOSE_BIT 7

// Converter result limits and error code.
`define ADC_MIN 10'h020
`define ADC_MAX 10'h3e3
`define ADC_ERR 10'h3f8

// Dither generator seed.
`define LFSR_SEED 16'hace1

`endif

// ---- hdl/bus_sensor_slave_logic.v ----
// Slave logic of a bus-powered sensor interface: decoder, control, reply.
`include "bus_sensor_defs.vh"

module bus_sensor_slave_logic #(
   parameter TIMEOUT_CYC = `BUS_TIMEOUT_CYC
) (
   input wire sys_clk, // System clock, 10 MHz.
   input wire rst, // Asynchronous reset, active high.
   input wire bus_below_frame, // Bus under frame threshold.
   input wire bus_below_signal, // Bus under signal threshold.
   input wire holding_cap_low, // Holding supply under threshold.
   input wire regulated_supply_low, // Regulated supply under threshold.
   input wire [9:0] adc_raw, // Converter raw result.
   input wire adc_done, // Converter finished, one-cycle pulse.
   input wire adc_fault, // Converter internal error with done.
   input wire [2:0] logic_pin_in, // Logic pin input levels.
   output reg response_current_on_ff, // Response current source enable.
   output reg pass_through_switch_ff, // Pass-through switch closed.
   output reg [2:0] logic_pin_out_ff, // Logic pin output levels.
   output reg [2:0] logic_pin_oe_n_ff, // Logic pin enable, low drives.
   output reg adc_start_ff, // Start conversion, one-cycle pulse.
   output reg adc_channel_ff, // Converter channel select.
   output reg dither_bit_ff, // Oscillator dither bitstream.
   output reg [3:0] bus_address_ff, // Stored bus address.
   output reg initialised_ff, // Device initialised.
   output reg internal_reset_ff // Filtered internal reset active.
);

   ////////////////////////////////////////////////////////////////////////
   // States and declarations.

   localparam ST_IDLE = 2'b01; // Bus idle.
   localparam ST_FRAME = 2'b10; // Word in progress.

   reg [1:0] state_ff; // Receiver state.
   reg [1:0] nxt_state;
   reg sig_prev_ff; // Last signal comparator level.
   reg bit_open_ff; // A bit has started.
   reg [11:0] low_cnt_ff; // Time low in current bit.
   reg [11:0] high_cnt_ff; // Time high in current bit.
   reg [19:0] rx_word_ff; // Received bits, newest in bit 0.
   reg [4:0] rx_count_ff; // Received bit count, saturating.
   reg [19:0] tx_sr_ff; // Reply bits, sent from bit 19.
   reg tx_act_ff; // Reply active in this word.
   reg [15:0] resp_data_ff; // Prepared reply data.
   reg resp_pend_ff; // Reply ready for the next word.
   reg adc_busy_ff; // Waiting for converter.
   reg [15:0] timeout_cnt_ff; // Bus-low time.
   reg [5:0] por_cnt_ff; // Supply-low time.
   reg soft_rst_ff; // Self reset request.
   reg [15:0] lfsr_ff; // Dither generator.

   wire fall_sig; // Signal threshold falling crossing.
   wire hi_wins; // Bit classified as one.
   wire frame_start;
   wire frame_end;
   wire [19:0] word_done; // Word with the last bit added.
   wire [4:0] count_done;
   wire len_ok;
   wire long_w;
   wire [3:0] rx_addr;
   wire [3:0] rx_cmd;
   wire [7:0] rx_data;
   wire crc_ok;
   wire addr_ok;
   wire word_ok;
   wire [9:0] adc_clamped;
   wire [9:0] adc_value;
   wire supply_low;

   ////////////////////////////////////////////////////////////////////////
   // Functions.

   // Serial check bits with x^4+1 over bits n-1 down to 4 of w.
   // Used for received words and for the reply, so kept in one place.
   function [3:0] crc_calc;
      input [19:0] w;
      input [4:0] n;
      integer i;
      reg [3:0] c;
      begin
         c = `CRC_SEED;
         for (i = 19; i >= 4; i = i - 1) begin
            if (i < n) begin
               c = {c[2:0], c[3] ^ w[i]};
            end
         end
         crc_calc = c;
      end
   endfunction

   // Saturating increment for the bit time counters.
   // Wrapping would turn a very slow zero into a one.
   function [11:0] sat_inc;
      input [11:0] v;
      begin
         sat_inc = (v == 12'hfff) ? v : v + 12'h001;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Receive decoding.

   // Comparator inputs are synchronous, so edges come from one register.
   assign fall_sig = bus_below_signal & ~sig_prev_ff;
   assign frame_start = (state_ff == ST_IDLE) & bus_below_frame;
   assign frame_end = (state_ff == ST_FRAME) & ~bus_below_frame;
   // A tie reads as zero; only a clear majority of high time is a one.
   assign hi_wins = high_cnt_ff > low_cnt_ff;
   assign word_done = {rx_word_ff[18:0], hi_wins};
   assign count_done = (rx_count_ff == 5'h1f) ? rx_count_ff : rx_count_ff + 5'h01;
   assign long_w = count_done == `WORD_LONG_BITS;
   assign len_ok = bit_open_ff & (long_w | (count_done == `WORD_SHORT_BITS));
   assign rx_data = word_done[19:12];
   assign rx_addr = word_done[11:8];
   assign rx_cmd = word_done[7:4];
   assign crc_ok = crc_calc(word_done, count_done) == word_done[3:0];
   // Before initialisation only the initialise command at its own address counts.
   assign addr_ok = initialised_ff ? (rx_addr == bus_address_ff) :
                    ((rx_addr == `INIT_ADDR) & (rx_cmd == `CMD_INIT));
   assign word_ok = frame_end & len_ok & crc_ok;

   // Receiver state choice.
   // Two states suffice: the bit phases live in the counters, not in states.
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (bus_below_frame) begin
               nxt_state = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (!bus_below_frame) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Bit timing, shifting and reply current.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         sig_prev_ff <= 1'b0;
         bit_open_ff <= 1'b0;
         low_cnt_ff <= 12'h000;
         high_cnt_ff <= 12'h000;
         rx_word_ff <= 20'h00000;
         rx_count_ff <= 5'h00;
         tx_sr_ff <= 20'h00000;
         tx_act_ff <= 1'b0;
         response_current_on_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sig_prev_ff <= bus_below_signal;
         // The source must never load an idle bus, not even during a reset.
         if (soft_rst_ff || internal_reset_ff || state_ff == ST_IDLE) begin
            response_current_on_ff <= 1'b0;
         end
         if (frame_start) begin
            // New word: clear the decoder and take the pending reply.
            bit_open_ff <= 1'b0;
            rx_count_ff <= 5'h00;
            rx_word_ff <= 20'h00000;
            tx_sr_ff <= {resp_data_ff, crc_calc({resp_data_ff, 4'h0}, 5'h14)};
            // A soft reset in this cycle wins, so a cleared device stays silent.
            tx_act_ff <= resp_pend_ff & ~soft_rst_ff;
         end else if (state_ff == ST_FRAME) begin
            if (fall_sig) begin
               // Close the previous bit, open the next one.
               if (bit_open_ff) begin
                  rx_word_ff <= word_done;
                  rx_count_ff <= count_done;
               end
               bit_open_ff <= 1'b1;
               low_cnt_ff <= 12'h001;
               high_cnt_ff <= 12'h000;
               response_current_on_ff <= tx_act_ff & tx_sr_ff[19];
               tx_sr_ff <= {tx_sr_ff[18:0], 1'b0};
            end else if (bus_below_signal) begin
               low_cnt_ff <= sat_inc(low_cnt_ff);
            end else begin
               high_cnt_ff <= sat_inc(high_cnt_ff);
            end
            if (frame_end) begin
               bit_open_ff <= 1'b0;
               response_current_on_ff <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Resets: bus-low timeout and filtered supply monitor.

   assign supply_low = holding_cap_low | regulated_supply_low;

   // Glitches shorter than the mask time do not reset the device.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timeout_cnt_ff <= 16'h0000;
         por_cnt_ff <= 6'h00;
         soft_rst_ff <= 1'b0;
         internal_reset_ff <= 1'b1;
      end else begin
         if (bus_below_frame) begin
            if (timeout_cnt_ff < TIMEOUT_CYC[15:0]) begin
               // Stops at the limit, so a long short circuit cannot wrap it.
               timeout_cnt_ff <= timeout_cnt_ff + 16'h0001;
            end
         end else begin
            timeout_cnt_ff <= 16'h0000;
         end
         if (supply_low) begin
            if (por_cnt_ff < `POR_MASK_CYC) begin
               por_cnt_ff <= por_cnt_ff + 6'h01;
            end
         end else begin
            por_cnt_ff <= 6'h00;
         end
         // The internal reset holds as long as the supply stays low.
         internal_reset_ff <= (supply_low && por_cnt_ff >= `POR_MASK_CYC - 1);
         soft_rst_ff <= bus_below_frame && timeout_cnt_ff >= TIMEOUT_CYC[15:0] - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Dither generator, free running on the single clock.

   // Taps 16, 14, 13, 11 give a maximal sequence.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lfsr_ff <= `LFSR_SEED;
         dither_bit_ff <= 1'b0;
      end else begin
         lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
         dither_bit_ff <= lfsr_ff[15];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter result shaping.

   assign adc_clamped = (adc_raw < `ADC_MIN) ? `ADC_MIN :
                        (adc_raw > `ADC_MAX) ? `ADC_MAX : adc_raw;
   // Pin one as a high input forces the error code, as does a fault.
   // The pin is read in the finishing cycle, the moment the result is taken.
   assign adc_value = (adc_fault | (logic_pin_oe_n_ff[1] & logic_pin_in[1])) ?
                      `ADC_ERR : adc_clamped;

   ////////////////////////////////////////////////////////////////////////
   // Command execution and reply preparation.

   // Soft and supply resets clear control state like a power-up, but keep the address, channel select and reply data.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pass_through_switch_ff <= 1'b0;
         logic_pin_out_ff <= 3'h0;
         logic_pin_oe_n_ff <= 3'h7;
         adc_start_ff <= 1'b0;
         adc_channel_ff <= 1'b0;
         adc_busy_ff <= 1'b0;
         bus_address_ff <= 4'h0;
         initialised_ff <= 1'b0;
         resp_data_ff <= 16'h0000;
         resp_pend_ff <= 1'b0;
      end else if (soft_rst_ff || internal_reset_ff) begin
         pass_through_switch_ff <= 1'b0;
         logic_pin_out_ff <= 3'h0;
         logic_pin_oe_n_ff <= 3'h7;
         adc_start_ff <= 1'b0;
         adc_busy_ff <= 1'b0;
         initialised_ff <= 1'b0;
         resp_pend_ff <= 1'b0;
      end else begin
         adc_start_ff <= 1'b0;
         // A reply is handed to the transmitter once per word.
         if (frame_start) begin
            resp_pend_ff <= 1'b0;
         end
         // Conversions run while the bus idles; the result becomes the reply.
         // A result that arrives with no request outstanding is ignored.
         if (adc_busy_ff && adc_done) begin
            adc_busy_ff <= 1'b0;
            resp_data_ff <= {6'h00, adc_value};
            resp_pend_ff <= 1'b1;
         end
         if (frame_end && !word_ok) begin
            // Corrupted word: no command runs, a pending conversion is dropped and nothing is answered.
            resp_pend_ff <= 1'b0;
            adc_busy_ff <= 1'b0;
         end else if (word_ok && addr_ok) begin
            case (rx_cmd)
               `CMD_INIT: begin
                  if (long_w) begin
                     bus_address_ff <= rx_data[3:0];
                     initialised_ff <= 1'b1;
                     if (rx_data[`SWITCH_CLOSE_BIT]) begin
                        pass_through_switch_ff <= 1'b1;
                     end
                     resp_data_ff <= {12'h000, rx_data[3:0]};
                     resp_pend_ff <= 1'b1;
                  end
               end
               `CMD_SAMPLE_ZERO, `CMD_SAMPLE_ONE: begin
                  adc_start_ff <= 1'b1;
                  adc_channel_ff <= rx_cmd[1];
                  adc_busy_ff <= 1'b1;
               end
               `CMD_PIN_CTRL: begin
                  if (long_w) begin
                     logic_pin_oe_n_ff <= ~rx_data[2:0];
                     logic_pin_out_ff <= rx_data[6:4];
                     resp_data_ff <= {8'h00, rx_data};
                     resp_pend_ff <= 1'b1;
                  end
               end
               `CMD_PIN_READ: begin
                  resp_data_ff <= {13'h0, logic_pin_in};
                  resp_pend_ff <= 1'b1;
               end
               `CMD_CLEAR: begin
                  // No reply is armed, so the next word carries nothing.
                  pass_through_switch_ff <= 1'b0;
                  logic_pin_oe_n_ff <= 3'h7;
                  logic_pin_out_ff <= 3'h0;
                  initialised_ff <= 1'b0;
                  adc_busy_ff <= 1'b0;
               end
               default: begin
                  // Unknown codes echo address and command back to the master.
                  resp_data_ff <= {8'h00, rx_addr, rx_cmd};
                  resp_pend_ff <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule

// ---- verif/bus_sensor_slave_logic_assertions.sv ----
// Port checker for the bus sensor slave logic, with its bind.
`include "bus_sensor_defs.vh"

module bus_sensor_slave_logic_checker #(
   parameter TIMEOUT_CYC = 300
) (
   input wire sys_clk, // System clock.
   input wire rst, // Asynchronous reset, active high.
   input wire bus_below_frame, // Bus under frame threshold.
   input wire bus_below_signal, // Bus under signal threshold.
   input wire holding_cap_low, // Holding supply low.
   input wire regulated_supply_low, // Regulated supply low.
   input wire response_current_on_ff, // Reply current enable.
   input wire pass_through_switch_ff, // Switch closed.
   input wire [2:0] logic_pin_oe_n_ff, // Pin enables, low drives.
   input wire adc_start_ff, // Conversion start pulse.
   input wire initialised_ff, // Device initialised.
   input wire internal_reset_ff // Filtered supply reset.
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   reg [15:0] low_cnt_ff; // Cycles the bus has stayed below frame threshold.
   reg [15:0] sup_cnt_ff; // Cycles a supply has stayed low.

   // Run lengths; wide enough that no test run can wrap them.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         low_cnt_ff <= 16'h0000;
         sup_cnt_ff <= 16'h0000;
      end else begin
         low_cnt_ff <= bus_below_frame ? low_cnt_ff + 16'h0001 : 16'h0000;
         sup_cnt_ff <= (holding_cap_low | regulated_supply_low) ? sup_cnt_ff + 16'h0001 : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_IDLE_OFF: assert property (!bus_below_frame && !$past(bus_below_frame) &&
      !$past(bus_below_frame, 2) |-> !response_current_on_ff) else $error("reply current on while idle");
   AST_RESP_AT_BIT: assert property ($changed(response_current_on_ff) |->
      ($past(bus_below_signal) && !$past(bus_below_signal, 2)) || !$past(bus_below_frame) ||
      $past(internal_reset_ff)) else $error("reply current changed away from a bit start");
   AST_START_PULSE: assert property (adc_start_ff |=> !adc_start_ff) else $error("start too long");
   AST_START_AT_END: assert property ($rose(adc_start_ff) |-> $past(bus_below_frame, 2) &&
      !$past(bus_below_frame)) else $error("conversion started outside a word end");
   AST_SWITCH_CLOSE: assert property ($rose(pass_through_switch_ff) |-> initialised_ff &&
      $past(bus_below_frame, 2) && !$past(bus_below_frame)) else $error("switch closed unasked");
   AST_PINS_DEFAULT: assert property ($rose(initialised_ff) |-> logic_pin_oe_n_ff == 3'h7)
      else $error("pins not inputs at initialisation");
   AST_RESET_STATE: assert property (internal_reset_ff && $past(internal_reset_ff) |->
      logic_pin_oe_n_ff == 3'h7 && !pass_through_switch_ff && !initialised_ff)
      else $error("state kept during supply reset");
   AST_SUPPLY_RESET: assert property (sup_cnt_ff > `POR_MASK_CYC + 2 |-> internal_reset_ff)
      else $error("supply drop did not reset");
   AST_BUS_TIMEOUT: assert property (low_cnt_ff > TIMEOUT_CYC + 2 |->
      !pass_through_switch_ff && !initialised_ff) else $error("bus timeout did not reset");
endmodule

bind bus_sensor_slave_logic bus_sensor_slave_logic_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_checker (
   .sys_clk(sys_clk), .rst(rst), .bus_below_frame(bus_below_frame),
   .bus_below_signal(bus_below_signal), .holding_cap_low(holding_cap_low),
   .regulated_supply_low(regulated_supply_low), .response_current_on_ff(response_current_on_ff),
   .pass_through_switch_ff(pass_through_switch_ff), .logic_pin_oe_n_ff(logic_pin_oe_n_ff),
   .adc_start_ff(adc_start_ff), .initialised_ff(initialised_ff),
   .internal_reset_ff(internal_reset_ff));

// ---- verif/central_master_model.sv ----
// Central master model: drives the bus comparator levels and reads the reply current.
module central_master_model (
   input wire sys_clk, // System clock.
   input wire response_current_on_ff, // Reply current from the device.
   output logic bus_below_frame, // Bus pulled below frame threshold.
   output logic bus_below_signal // Bus pulled below signal threshold.
);
   timeunit 1ns;
   timeprecision 1ns;

   // The bus idles high, above both thresholds.
   initial begin
      bus_below_frame = 1'b0;
      bus_below_signal = 1'b0;
   end

   // Sends n bits of w, first bit highest, and shifts in the reply bit of each.
   task automatic send_word(input logic [19:0] w, input int n, output logic [19:0] r);
      r = 20'h00000;
      @(negedge sys_clk);
      bus_below_frame = 1'b1;
      repeat (2) @(negedge sys_clk);
      for (int i = n - 1; i >= 0; i--) begin
         bus_below_signal = 1'b1;
         repeat (2) @(negedge sys_clk);
         r = {r[18:0], response_current_on_ff};
         repeat (w[i] ? 0 : 2) @(negedge sys_clk);
         bus_below_signal = 1'b0;
         repeat (w[i] ? 4 : 2) @(negedge sys_clk);
      end
      bus_below_frame = 1'b0;
      @(negedge sys_clk);
   endtask

   // Holds the bus low with no bits, as a shorted line would.
   task automatic hold_low(input int n);
      @(negedge sys_clk);
      bus_below_frame = 1'b1;
      repeat (n) @(negedge sys_clk);
      bus_below_frame = 1'b0;
      @(negedge sys_clk);
   endtask
endmodule

// ---- verif/bus_sensor_slave_logic_bench.sv ----
// Self-checking bench of the bus sensor slave logic.
`include "bus_sensor_defs.vh"

module bus_sensor_slave_logic_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TMO = 300; // Short timeout, still longer than one long word.
   logic sys_clk, rst, holding_cap_low, regulated_supply_low, adc_done, adc_fault, s, d0, d1;
   logic [9:0] adc_raw; // Converter result driven by the bench.
   logic [2:0] logic_pin_in; // Pin input levels.
   logic [19:0] rsp, prev; // Reply seen and reply expected next.
   wire bus_below_frame, bus_below_signal, response_current_on_ff, pass_through_switch_ff;
   wire adc_start_ff, adc_channel_ff, dither_bit_ff, initialised_ff, internal_reset_ff;
   wire [2:0] logic_pin_out_ff, logic_pin_oe_n_ff;
   wire [3:0] bus_address_ff;
   int fails, tests_run;
   logic [9:0] raw_t [6] = '{10'h005, 10'h3f0, 10'h020, 10'h3e3, 10'h200, 10'h200};
   logic [9:0] exp_t [6] = '{10'h020, 10'h3e3, 10'h020, 10'h3e3, 10'h3f8, 10'h3f8};

   bus_sensor_slave_logic #(.TIMEOUT_CYC(TMO)) u_dut (.sys_clk(sys_clk), .rst(rst),
      .bus_below_frame(bus_below_frame), .bus_below_signal(bus_below_signal),
      .holding_cap_low(holding_cap_low), .regulated_supply_low(regulated_supply_low),
      .adc_raw(adc_raw), .adc_done(adc_done), .adc_fault(adc_fault), .logic_pin_in(logic_pin_in),
      .response_current_on_ff(response_current_on_ff),
      .pass_through_switch_ff(pass_through_switch_ff),
      .logic_pin_out_ff(logic_pin_out_ff), .logic_pin_oe_n_ff(logic_pin_oe_n_ff),
      .adc_start_ff(adc_start_ff), .adc_channel_ff(adc_channel_ff), .dither_bit_ff(dither_bit_ff),
      .bus_address_ff(bus_address_ff), .initialised_ff(initialised_ff),
      .internal_reset_ff(internal_reset_ff));
   central_master_model u_master (.sys_clk(sys_clk),
      .response_current_on_ff(response_current_on_ff),
      .bus_below_frame(bus_below_frame), .bus_below_signal(bus_below_signal));

   ////////////////////////////////////////////////////////////////////////////
   // Check bits run serially over the payload from the fixed seed.
   function automatic logic [3:0] crc(input logic [15:0] p, input int n);
      logic [3:0] c;
      c = `CRC_SEED;
      for (int i = n - 1; i >= 0; i--)
         c = {c[2:0], c[3] ^ p[i]};
      return c;
   endfunction

   // Long command word, data first, then address, command and check bits.
   function automatic logic [19:0] lw(input logic [7:0] d, input logic [3:0] a,
      input logic [3:0] c);
      return {d, a, c, crc({d, a, c}, 16)};
   endfunction

   // Short command word in the low twelve bits: address, command and check bits.
   function automatic logic [19:0] sw(input logic [3:0] a, input logic [3:0] c);
      return {8'h00, a, c, crc({8'h00, a, c}, 8)};
   endfunction

   // Reply word: sixteen bits followed by their check bits.
   function automatic logic [19:0] rep(input logic [15:0] r);
      return {r, crc(r, 16)};
   endfunction

   // Compares and counts; reports a mismatch at once.
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Sends one word and keeps the reply that came back during it.
   task automatic xfer(input logic [19:0] w, input int n = 20);
      u_master.send_word(w, n, rsp);
   endtask

   // Watches a few cycles after a word for a conversion start.
   task automatic seen_start(output logic st);
      st = 1'b0;
      // The pulse is already up when the word task returns, so look first.
      repeat (4) begin
         st = st | (adc_start_ff === 1'b1);
         @(negedge sys_clk);
      end
   endtask

   // Answers a conversion start with one finished result.
   task automatic conv(input logic [9:0] raw, input logic flt);
      seen_start(s);
      chk(s, 1'b1);
      adc_raw = raw;
      adc_fault = flt;
      adc_done = 1'b1;
      @(negedge sys_clk);
      adc_done = 1'b0;
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock, plus a monitor of both dither levels outside reset.
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      if (!rst && dither_bit_ff === 1'b1) d1 = 1'b1;
      if (!rst && dither_bit_ff === 1'b0) d0 = 1'b1;
   end

   // Cuts a hang short; the tests take well under a millisecond.
   initial begin
      #2ms;
      fails++;
      final_report();
   end

   // Main sequence of commands and expected results.
   initial begin
      {rst, holding_cap_low, regulated_supply_low, adc_done, adc_fault, d0, d1} = 7'h40;
      {adc_raw, logic_pin_in, fails, tests_run} = '0;
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({logic_pin_oe_n_ff, pass_through_switch_ff, initialised_ff}, 5'h1c);
      xfer(lw(8'h00, 4'h5, `CMD_PIN_READ));
      chk({initialised_ff, rsp}, 21'h0);
      xfer(lw(8'h85, `INIT_ADDR, `CMD_INIT));
      chk({bus_address_ff, pass_through_switch_ff, initialised_ff}, 6'h17);
      xfer(lw(8'h51, 4'h5, `CMD_PIN_CTRL));
      chk(rsp, rep(16'h0005));
      chk({logic_pin_oe_n_ff, logic_pin_out_ff}, 6'h35);
      xfer(lw(8'h00, 4'h5, `CMD_SAMPLE_ZERO), 19);
      chk(rsp[18:0], rep(16'h0051) >> 1);
      seen_start(s);
      chk(s, 1'b0);
      prev = 20'h0;
      for (int k = 0; k < 6; k++) begin
         logic_pin_in = (k == 5) ? 3'h2 : 3'h0;
         xfer(lw(8'h00, 4'h5, k[0] ? `CMD_SAMPLE_ONE : `CMD_SAMPLE_ZERO));
         chk(rsp, prev);
         conv(raw_t[k], k == 4);
         chk(adc_channel_ff, k[0]);
         prev = rep({6'h00, exp_t[k]});
      end
      xfer(lw(8'h00, 4'h5, `CMD_PIN_READ));
      chk(rsp, prev);
      xfer(sw(4'h5, 4'h7), 12);
      chk(rsp, rep(16'h0002) >> 8);
      xfer(sw(4'h5, `CMD_PIN_READ), 12);
      chk(rsp, rep(16'h0057) >> 8);
      xfer(lw(8'h00, 4'h5, `CMD_SAMPLE_ZERO) ^ 20'h1);
      chk(rsp, rep(16'h0002));
      seen_start(s);
      chk(s, 1'b0);
      xfer(lw(8'h00, 4'h5, `CMD_PIN_READ));
      chk(rsp, 20'h0);
      xfer(lw(8'h00, 4'h5, `CMD_CLEAR));
      chk({pass_through_switch_ff, initialised_ff, logic_pin_oe_n_ff}, 5'h07);
      xfer(lw(8'h86, `INIT_ADDR, `CMD_INIT));
      chk({bus_address_ff, pass_through_switch_ff}, 5'hd);
      u_master.hold_low(TMO + 20);
      chk({pass_through_switch_ff, initialised_ff}, 2'h0);
      xfer(lw(8'h86, `INIT_ADDR, `CMD_INIT));
      holding_cap_low = 1'b1;
      repeat (40) @(negedge sys_clk);
      chk({internal_reset_ff, pass_through_switch_ff}, 2'h2);
      holding_cap_low = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(internal_reset_ff, 1'b0);
      xfer(lw(8'h07, 4'h6, `CMD_PIN_CTRL));
      chk(logic_pin_oe_n_ff, 3'h7);
      chk({d1, d0}, 2'h3);
      final_report();
   end
endmodule
